// ---- design/flash_guard_cfg.svh ----
`ifndef FLASH_GUARD_CFG_SVH
`define FLASH_GUARD_CFG_SVH

`define FG_ADDR_W   17
`define FG_WORD_W   16
`define FG_RESET_PC 17'h00000

// application table start per size (end = boot start - 1)
`define FG_TBL_128  17'h0f000
`define FG_TBL_64   17'h07800
`define FG_TBL_32   17'h03800
`define FG_TBL_16   17'h01800
// boot start and end per size
`define FG_BOOT_128 17'h10000
`define FG_BEND_128 17'h10fff
`define FG_BOOT_64  17'h08000
`define FG_BEND_64  17'h087ff
`define FG_BOOT_32  17'h04000
`define FG_BEND_32  17'h047ff
`define FG_BOOT_16  17'h02000
`define FG_BEND_16  17'h027ff

// lock encodings: 2'b11 open, 2'b10 no write, 2'b0x no read or write
`define FG_LOCK_OPEN  2'h3
`define FG_LOCK_NOWR  2'h2

`endif

// ---- design/flash_guard_pkg.sv ----
`default_nettype none
package flash_guard_pkg;

	typedef enum logic [1:0]
	{
		SIZE_16K  = 2'h0,
		SIZE_32K  = 2'h1,
		SIZE_64K  = 2'h2,
		SIZE_128K = 2'h3
	} mem_size_t;

	typedef enum logic [1:0]
	{
		SEC_APP   = 2'h0,
		SEC_TABLE = 2'h1,
		SEC_BOOT  = 2'h2,
		SEC_NONE  = 2'h3
	} section_t;

	typedef struct packed
	{
		logic [1:0] app;
		logic [1:0] table_;
		logic [1:0] boot;
	} lock_bits_t;

	typedef struct packed
	{
		logic        valid;
		logic [16:0] addr;
		logic [15:0] data;
	} store_req_t;

	typedef enum logic [1:0]
	{
		FETCH_IDLE = 2'h0,
		FETCH_RUN  = 2'h1,
		FETCH_HOLD = 2'h3
	} fetch_state_t;

endpackage
`default_nettype wire

// ---- design/program_flash_section_guard.sv ----
`include "flash_guard_cfg.svh"
`default_nettype none
module program_flash_section_guard
#(
	parameter int ADDR_W = `FG_ADDR_W,
	parameter int WORD_W = `FG_WORD_W,
	parameter int DEPTH  = 69632
)
(
	input  wire logic                          clk,
	input  wire logic                          rstn,
	input  wire flash_guard_pkg::mem_size_t    memSize,
	input  wire flash_guard_pkg::lock_bits_t   lockBits,
	input  wire logic                          fetchEnable,
	input  wire logic                          jumpValid,
	input  wire logic [ADDR_W-1:0]             jumpTarget,
	output logic [ADDR_W-1:0]                  fetch_pointer,
	output logic [WORD_W-1:0]                  instrWord,
	output logic [ADDR_W-1:0]                  instrAddr,
	output logic                               instrValid,
	input  wire flash_guard_pkg::store_req_t   storeReq,
	output logic                               storeDone,
	output logic                               storeBlocked,
	input  wire logic                          dataReadValid,
	input  wire logic [ADDR_W-1:0]             dataReadAddr,
	output logic [WORD_W-1:0]                  dataReadWord,
	output logic                               dataReadBlocked
);

	// ==========================================================
	// memory and section decode
	// ==========================================================
	// 16-bit word array
	logic [WORD_W-1:0] flashMem [0:DEPTH-1];

	logic [ADDR_W-1:0] tblStart;
	logic [ADDR_W-1:0] bootStart;
	logic [ADDR_W-1:0] bootEnd;

	always_comb
	begin
		case (memSize)
			flash_guard_pkg::SIZE_128K:
			begin
				tblStart  = `FG_TBL_128;
				bootStart = `FG_BOOT_128;
				bootEnd   = `FG_BEND_128;
			end
			flash_guard_pkg::SIZE_64K:
			begin
				tblStart  = `FG_TBL_64;
				bootStart = `FG_BOOT_64;
				bootEnd   = `FG_BEND_64;
			end
			flash_guard_pkg::SIZE_32K:
			begin
				tblStart  = `FG_TBL_32;
				bootStart = `FG_BOOT_32;
				bootEnd   = `FG_BEND_32;
			end
			default:
			begin
				tblStart  = `FG_TBL_16;
				bootStart = `FG_BOOT_16;
				bootEnd   = `FG_BEND_16;
			end
		endcase
	end

	function automatic flash_guard_pkg::section_t sectionOf(
		input logic [ADDR_W-1:0] a,
		input logic [ADDR_W-1:0] ts,
		input logic [ADDR_W-1:0] bs,
		input logic [ADDR_W-1:0] be);
		// application from zero up to table start
		if (a < ts)
			return flash_guard_pkg::SEC_APP;
		// table is a third section between application and boot
		else if (a < bs)
			return flash_guard_pkg::SEC_TABLE;
		else if (a <= be)
			return flash_guard_pkg::SEC_BOOT;
		else
			return flash_guard_pkg::SEC_NONE;
	endfunction

	function automatic logic [1:0] lockOf(
		input flash_guard_pkg::section_t s,
		input flash_guard_pkg::lock_bits_t l);
		// each section checks its own lock bits
		case (s)
			flash_guard_pkg::SEC_APP:   return l.app;
			flash_guard_pkg::SEC_TABLE: return l.table_;
			flash_guard_pkg::SEC_BOOT:  return l.boot;
			default:                    return 2'h0;
		endcase
	endfunction

	// ==========================================================
	// fetch pipeline
	// ==========================================================
	flash_guard_pkg::fetch_state_t state;
	flash_guard_pkg::section_t     instrSection;

	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
			state <= flash_guard_pkg::FETCH_IDLE;
		else
			case (state)
				flash_guard_pkg::FETCH_IDLE:
					if (fetchEnable)
						state <= flash_guard_pkg::FETCH_RUN;
				flash_guard_pkg::FETCH_RUN:
					if (!fetchEnable)
						state <= flash_guard_pkg::FETCH_HOLD;
				flash_guard_pkg::FETCH_HOLD:
					if (fetchEnable)
						state <= flash_guard_pkg::FETCH_RUN;
				default:
					state <= flash_guard_pkg::FETCH_IDLE;
			endcase
	end

	logic fetchNow;
	assign fetchNow = fetchEnable;

	// pointer starts at zero after reset
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
			fetch_pointer <= `FG_RESET_PC;
		else if (jumpValid)
			fetch_pointer <= jumpTarget;
		else if (fetchNow)
			fetch_pointer <= fetch_pointer + ADDR_W'(1);
	end

	// next word read while current executes
	// code may run from any section; words past the array read zero
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			instrWord    <= '0;
			instrAddr    <= '0;
			instrValid   <= 1'b0;
			instrSection <= flash_guard_pkg::SEC_APP;
		end
		else
		begin
			instrValid <= fetchNow && !jumpValid;
			if (fetchNow && !jumpValid)
			begin
				instrAddr    <= fetch_pointer;
				instrSection <= sectionOf(fetch_pointer, tblStart, bootStart, bootEnd);
				instrWord    <= (fetch_pointer < ADDR_W'(DEPTH))
					? flashMem[fetch_pointer] : '0;
			end
		end
	end

	// ==========================================================
	// self-programming store path
	// ==========================================================
	flash_guard_pkg::section_t storeSection;
	logic                      storeAllowed;

	always_comb
	begin
		storeSection = sectionOf(storeReq.addr, tblStart, bootStart, bootEnd);
		// issuing word must come from boot code
		storeAllowed = instrValid
			&& instrSection == flash_guard_pkg::SEC_BOOT
			&& storeSection != flash_guard_pkg::SEC_NONE
			&& lockOf(storeSection, lockBits) == `FG_LOCK_OPEN;
	end

	always_ff @(posedge clk)
	begin
		if (storeReq.valid && storeAllowed)
			flashMem[storeReq.addr] <= storeReq.data;
	end

	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			storeDone    <= 1'b0;
			storeBlocked <= 1'b0;
		end
		else
		begin
			storeDone    <= storeReq.valid && storeAllowed;
			storeBlocked <= storeReq.valid && !storeAllowed;
		end
	end

	// ==========================================================
	// data reads from application, table and boot sections
	// ==========================================================
	flash_guard_pkg::section_t readSection;
	logic [1:0]                readLock;
	logic                      readAllowed;

	always_comb
	begin
		readSection = sectionOf(dataReadAddr, tblStart, bootStart, bootEnd);
		readLock    = lockOf(readSection, lockBits);
		readAllowed = readSection != flash_guard_pkg::SEC_NONE
			&& readLock[1];
	end

	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			dataReadWord    <= '0;
			dataReadBlocked <= 1'b0;
		end
		else
		begin
			dataReadBlocked <= dataReadValid && !readAllowed;
			if (dataReadValid)
				dataReadWord <= readAllowed ? flashMem[dataReadAddr] : '0;
		end
	end

	// ==========================================================
	// checks
	// ==========================================================
	a_reset_pointer: assert property (@(posedge clk)
		$rose(rstn) |-> fetch_pointer == `FG_RESET_PC)
		else $error("fetch pointer not zero after reset");

	a_store_boot_only: assert property (@(posedge clk) disable iff (!rstn)
		storeReq.valid && instrSection != flash_guard_pkg::SEC_BOOT |=> !storeDone && storeBlocked)
		else $error("store from non-boot code accepted");

	a_store_locked: assert property (@(posedge clk) disable iff (!rstn)
		storeReq.valid && lockOf(storeSection, lockBits) != `FG_LOCK_OPEN |=> storeBlocked)
		else $error("store to locked section accepted");

	a_prefetch_addr: assert property (@(posedge clk) disable iff (!rstn)
		fetchEnable && !jumpValid |=> instrValid && instrAddr == $past(fetch_pointer))
		else $error("prefetch address mismatch");

	a_pointer_step: assert property (@(posedge clk) disable iff (!rstn)
		fetchEnable && !jumpValid |=> fetch_pointer == $past(fetch_pointer) + ADDR_W'(1))
		else $error("fetch pointer did not advance");

	a_table_decode: assert property (@(posedge clk) disable iff (!rstn)
		memSize == flash_guard_pkg::SIZE_64K |-> tblStart == `FG_TBL_64)
		else $error("table start wrong for 64K");

	a_boot_decode: assert property (@(posedge clk) disable iff (!rstn)
		memSize == flash_guard_pkg::SIZE_16K |-> bootEnd == `FG_BEND_16 && bootStart == `FG_BOOT_16)
		else $error("boot range wrong for 16K");

	a_read_locked: assert property (@(posedge clk) disable iff (!rstn)
		dataReadValid && !readAllowed |=> dataReadBlocked && dataReadWord == '0)
		else $error("locked read returned data");

	a_app_decode: assert property (@(posedge clk) disable iff (!rstn)
		storeReq.valid && storeReq.addr < tblStart |-> storeSection == flash_guard_pkg::SEC_APP)
		else $error("application decode wrong");

	a_fetch_state: assert property (@(posedge clk) disable iff (!rstn)
		fetchEnable |=> state == flash_guard_pkg::FETCH_RUN)
		else $error("fetch state not running");

	a_jump_load: assert property (@(posedge clk) disable iff (!rstn)
		jumpValid |=> !instrValid && fetch_pointer == $past(jumpTarget))
		else $error("jump did not load fetch pointer");

	a_fetch_idle: assert property (@(posedge clk) disable iff (!rstn)
		!fetchEnable && !jumpValid |=> !instrValid && $stable(instrAddr) && $stable(fetch_pointer))
		else $error("fetch moved while idle");

	a_store_result: assert property (@(posedge clk) disable iff (!rstn)
		!(storeDone && storeBlocked))
		else $error("store both done and blocked");

	a_table_open: assert property (@(posedge clk) disable iff (!rstn)
		storeReq.valid && instrValid && instrSection == flash_guard_pkg::SEC_BOOT
		&& storeSection == flash_guard_pkg::SEC_TABLE
		&& lockBits.table_ == `FG_LOCK_OPEN |=> storeDone)
		else $error("open table store refused");

	a_table_lock: assert property (@(posedge clk) disable iff (!rstn)
		storeReq.valid && storeSection == flash_guard_pkg::SEC_TABLE
		&& lockBits.table_ != `FG_LOCK_OPEN |=> storeBlocked)
		else $error("locked table store accepted");

	a_read_open: assert property (@(posedge clk) disable iff (!rstn)
		dataReadValid && readSection != flash_guard_pkg::SEC_NONE && readLock[1]
		|=> !dataReadBlocked)
		else $error("open read refused");

	a_read_idle: assert property (@(posedge clk) disable iff (!rstn)
		!dataReadValid |=> !dataReadBlocked)
		else $error("read blocked without request");

endmodule // program_flash_section_guard
`default_nettype wire

// ---- tb/core_model.sv ----
`default_nettype none
module core_model
(
	input  wire logic                     clk,
	output logic                          fetchEnable,
	output logic                          jumpValid,
	output logic [16:0]                   jumpTarget,
	output var flash_guard_pkg::store_req_t storeReq,
	output logic                          dataReadValid,
	output logic [16:0]                   dataReadAddr
);
	timeunit 1ns;
	timeprecision 1ps;

	initial
	begin
		fetchEnable = 1'h0;
		jumpValid = 1'h0;
		jumpTarget = 17'h00000;
		storeReq = '0;
		dataReadValid = 1'h0;
		dataReadAddr = 17'h00000;
	end

	task automatic fetchN(input logic j, input logic [16:0] f, input int n);
		@(negedge clk);
		jumpValid <= j;
		jumpTarget <= f;
		repeat (n)
		begin
			@(negedge clk);
			jumpValid <= 1'h0;
			jumpTarget <= ~f;
			fetchEnable <= 1'h1;
		end
		@(negedge clk);
		fetchEnable <= 1'h0;
	endtask

	// store issued in the cycle right after the fetch that grants it
	task automatic store(input logic [16:0] f, input logic [16:0] a, input logic [15:0] d);
		fetchN(1'h1, f, 1);
		storeReq <= '{1'b1, a, d};
		@(negedge clk);
		storeReq <= '{1'b0, ~a, ~d};
	endtask

	task automatic rd(input logic [16:0] a);
		@(negedge clk);
		dataReadValid <= 1'h1;
		dataReadAddr <= a;
		@(negedge clk);
		dataReadValid <= 1'h0;
		dataReadAddr <= ~a;
	endtask
endmodule // core_model
`default_nettype wire

// ---- tb/program_flash_section_guard_test.sv ----
`default_nettype none
module program_flash_section_guard_test;
	timeunit 1ns;
	timeprecision 1ps;

	logic clk = 1'h0;
	logic rstn = 1'h0;
	flash_guard_pkg::mem_size_t memSize = flash_guard_pkg::SIZE_128K;
	flash_guard_pkg::lock_bits_t lockBits = 6'h3f;
	flash_guard_pkg::store_req_t storeReq;
	logic fetchEnable, jumpValid, instrValid, storeDone, storeBlocked;
	logic dataReadValid, dataReadBlocked;
	logic [16:0] jumpTarget, fetch_pointer, instrAddr, dataReadAddr;
	logic [15:0] instrWord, dataReadWord;
	int err_total = 0;
	int compares = 0;
	logic [16:0] tbl [4] = '{17'h01800, 17'h03800, 17'h07800, 17'h0f000};
	logic [16:0] bst [4] = '{17'h02000, 17'h04000, 17'h08000, 17'h10000};
	logic [16:0] bnd [4] = '{17'h027ff, 17'h047ff, 17'h087ff, 17'h10fff};

	always #12.5 clk = ~clk;

	program_flash_section_guard dut (.clk(clk), .rstn(rstn), .memSize(memSize),
		.lockBits(lockBits), .fetchEnable(fetchEnable), .jumpValid(jumpValid),
		.jumpTarget(jumpTarget), .fetch_pointer(fetch_pointer), .instrWord(instrWord),
		.instrAddr(instrAddr), .instrValid(instrValid), .storeReq(storeReq),
		.storeDone(storeDone), .storeBlocked(storeBlocked), .dataReadValid(dataReadValid),
		.dataReadAddr(dataReadAddr), .dataReadWord(dataReadWord),
		.dataReadBlocked(dataReadBlocked));

	core_model cpu (.clk(clk), .fetchEnable(fetchEnable), .jumpValid(jumpValid),
		.jumpTarget(jumpTarget), .storeReq(storeReq), .dataReadValid(dataReadValid),
		.dataReadAddr(dataReadAddr));

	// ====================================
	// checking and verdict
	task automatic chk(input logic ok, input string m);
		compares++;
		if (ok !== 1'h1)
		begin
			err_total++;
			$display("[FAIL] %0t %s", $time, m);
		end
	endtask

	task automatic give_verdict;
		$display("compares %0d errors %0d", compares, err_total);
		if (err_total == 0 && compares > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	// ====================================
	// scenarios
	task automatic reset_fetch;
		chk(fetch_pointer === 17'h00000, "pointer after reset");
		cpu.fetchN(1'h0, 17'h00000, 2);
		chk(instrAddr === 17'h00001 && fetch_pointer === 17'h00002, "prefetch");
	endtask

	task automatic section_sweep;
		for (int s = 0; s < 4; s++)
		begin
			memSize = flash_guard_pkg::mem_size_t'(s);
			cpu.store(bst[s], tbl[s], 16'h5a00 + 16'(s));
			chk(storeDone === 1'h1, "boot store to table");
			cpu.store(bnd[s], tbl[s] - 17'h1, 16'h0a5f);
			chk(storeDone === 1'h1, "boot end store");
			cpu.rd(tbl[s]);
			chk(dataReadWord === 16'h5a00 + 16'(s), "table word");
			cpu.rd(tbl[s] - 17'h1);
			chk(dataReadWord === 16'h0a5f, "app top word");
			cpu.store(tbl[s], tbl[s] - 17'h1, 16'h1111);
			chk(storeBlocked === 1'h1 && instrAddr === tbl[s], "table code store");
			cpu.rd(tbl[s] - 17'h1);
			chk(dataReadWord === 16'h0a5f, "word changed");
			cpu.store(bst[s], bnd[s] + 17'h1, 16'h2222);
			chk(storeBlocked === 1'h1, "past boot end");
		end
	endtask

	task automatic lock_tests;
		memSize = flash_guard_pkg::SIZE_128K;
		lockBits = '{2'h3, 2'h2, 2'h3};
		cpu.store(17'h10000, 17'h0f000, 16'hdead);
		chk(storeBlocked === 1'h1, "table write lock");
		cpu.rd(17'h0f000);
		chk(dataReadWord === 16'h5a03 && dataReadBlocked === 1'h0, "table kept");
		lockBits = '{2'h2, 2'h3, 2'h3};
		cpu.store(17'h10000, 17'h0efff, 16'hbeef);
		chk(storeBlocked === 1'h1, "app write lock");
		cpu.store(17'h10000, 17'h0f000, 16'h1234);
		chk(storeDone === 1'h1, "table lock apart");
		lockBits = '{2'h3, 2'h0, 2'h3};
		cpu.rd(17'h0f000);
		chk(dataReadBlocked === 1'h1 && dataReadWord === 16'h0000, "table read lock");
		lockBits = '{2'h3, 2'h3, 2'h0};
		cpu.rd(17'h10000);
		chk(dataReadBlocked === 1'h1, "boot read lock");
	endtask

	task automatic two_word_fetch;
		cpu.fetchN(1'h1, 17'h017ff, 1);
		chk(instrValid === 1'h1 && instrAddr === 17'h017ff && instrWord === 16'h0a5f, "low word");
		cpu.fetchN(1'h0, 17'h00000, 1);
		chk(instrValid === 1'h1 && instrAddr === 17'h01800 && instrWord === 16'h5a00, "high word");
	endtask

	initial
	begin
		repeat (12) @(negedge clk);
		rstn = 1'h1;
		reset_fetch();
		section_sweep();
		lock_tests();
		two_word_fetch();
		give_verdict();
	end

	// about 130 cycles expected; cut off far beyond that
	initial
	begin
		#(25 * 3000);
		err_total++;
		give_verdict();
	end
endmodule // program_flash_section_guard_test
`default_nettype wire
